// file: morf_defines.svh
`ifndef MORF_DEFINES_SVH
`define MORF_DEFINES_SVH
// ---------------------------------------------------------------
// File addresses of the operation registers
// ---------------------------------------------------------------
`define MORF_OFS_IND     6'h00
`define MORF_OFS_TMR     6'h01
`define MORF_OFS_PCL     6'h02
`define MORF_OFS_STAT    6'h03
`define MORF_OFS_RSEL    6'h04
`define MORF_OFS_P5      6'h05
`define MORF_OFS_P6      6'h06
`define MORF_OFS_P7      6'h07
`define MORF_OFS_P8      6'h08
`define MORF_OFS_P9      6'h09
`define MORF_OFS_EECMD   6'h0A
`define MORF_OFS_PDCTL   6'h0B
`define MORF_OFS_RAM_LO  6'h10
`define MORF_OFS_BANKED  6'h20
`define MORF_BUS_PC_ADDR 10'h040
// ---------------------------------------------------------------
// Field positions and masks
// ---------------------------------------------------------------
`define MORF_ST_C        0
`define MORF_ST_DC       1
`define MORF_ST_Z        2
`define MORF_ST_P        3
`define MORF_ST_T        4
`define MORF_ST_WR_MASK  8'hE7
`define MORF_P7_MASK     8'hF7
`define MORF_P9_MASK     8'h6F
// ---------------------------------------------------------------
// Reset values and vectors
// ---------------------------------------------------------------
`define MORF_RST_STAT    8'h18
`define MORF_RST_ZERO    8'h00
`define MORF_RST_EECMD   8'hFF
`define MORF_PC_RESET    13'h0000
`define MORF_INT_VECTOR  13'h0001
`define MORF_RAM_BYTES   144
`define MORF_STACK_DEPTH 8
`endif

// file: morf_pkg.sv
package morf_pkg;
	// Arithmetic flag source
	typedef enum logic [2:0] {
		MORF_ALU_NONE, MORF_ALU_ADD, MORF_ALU_SUB,
		MORF_ALU_RRC, MORF_ALU_RLC, MORF_ALU_LOGIC
	} morf_alu_op_t;
	// Program counter command
	typedef enum logic [2:0] {
		MORF_PC_HOLD, MORF_PC_STEP, MORF_PC_JUMP,
		MORF_PC_CALL, MORF_PC_RET, MORF_PC_INT
	} morf_pc_op_t;
	// Core data-memory request
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [5:0] addr;
		logic [7:0] wdata;
	} morf_dm_req_t;
	// Core ALU flag request
	typedef struct packed {
		morf_alu_op_t op;
		logic [7:0]   a;
		logic [7:0]   b;
	} morf_alu_req_t;
	// Resolved file location
	typedef struct packed {
		logic       ok;
		logic [1:0] bank;
		logic [5:0] addr;
	} morf_ref_t;
	// Port data register outputs
	typedef struct packed {
		logic [7:0] p5;
		logic [7:0] p6;
		logic [7:0] p7;
		logic [7:0] p8;
		logic [7:0] p9;
	} morf_ports_t;
endpackage : morf_pkg

// file: morf_top.sv
// Functional notes
// - 13-bit counter spans eight 1K-word pages
// - Resets clear program counter to zero
// - Every interrupt vectors to address one
// - 144 bytes of general data RAM
// - Indirect location accesses address in pointer
// - Timer read/write, increments each instruction cycle
// - Timer wrap sets flag; enable gates interrupt
// - Both resets load timer with zero
// - Eight-level return address stack
// - Low PC byte readable; page bits high
// - Carry: add carry-out, subtract inverted borrow
// - Rotates load carry with shifted-out bit
// - Half carry from bit 3, borrow inverted
// - Zero flag follows all-zero result
// - Power-down flag set/cleared, kept over watchdog
// - Time-out flag set, cleared by watchdog overflow
// - Port wake leaves time-out 1, power-down 0
// - Page code n maps to n times 0x400
// - Pointer addresses 0x00-0x1F are common
// - Pointer bits 7:6 choose one of four banks
// - Port 7 bits 4,5 shared; bit 3 absent
// - Status resets time-out, power-down high, page zero
`timescale 1ns/1ps
`default_nettype none
`include "morf_defines.svh"
module morf_top
(
	input  wire logic                   clk_sys,
	input  wire logic                   rst,
	// AHB-Lite slave
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic [31:0]                 hrdata,
	// Instruction core side
	input  wire logic                   wdt_reset,
	input  wire logic                   instr_cycle,
	input  wire morf_pkg::morf_dm_req_t dm_req,
	output logic [7:0]                  dm_rdata,
	input  wire morf_pkg::morf_alu_req_t alu_req,
	input  wire morf_pkg::morf_pc_op_t  pc_op,
	input  wire logic [9:0]             jump_target,
	output logic [12:0]                 fetch_addr,
	output logic [7:0]                  core_status,
	// Power events
	input  wire logic                   watchdog_clear_instr,
	input  wire logic                   wdt_timeout,
	input  wire logic                   sleep_enter,
	input  wire logic                   port_wake,
	// Timer interrupt
	input  wire logic                   timer_overflow_enable,
	input  wire logic                   timer_flag_clr,
	output logic                        timer_overflow_flag,
	output logic                        timer_irq,
	// Port data registers
	output morf_pkg::morf_ports_t       port_data
);
	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	logic [7:0]  ram_r [`MORF_RAM_BYTES];   // Common and banked RAM
	logic [12:0] stack_r [`MORF_STACK_DEPTH]; // Return addresses
	logic [2:0]  sp_r;                       // Next free stack slot
	logic [12:0] pc_r;                       // Program counter
	logic [7:0]  timer_r;                    // Cycle timer
	logic        tof_r;                      // Timer overflow flag
	logic        irq_r;                      // Gated interrupt
	logic [7:0]  stat_r;                     // Status register
	logic [7:0]  rsel_r;                     // RAM pointer and bank
	logic [7:0]  eecmd_r;                    // EEPROM command byte
	logic [7:0]  pdctl_r;                    // Pattern detect control
	morf_pkg::morf_ports_t ports_r;          // Port data
	logic [7:0]  dm_rdata_r;                 // Core read data
	logic [31:0] hrdata_r;                   // Bus read data
	logic        dp_wr_r;                    // Bus write in data phase
	logic [5:0]  dp_addr_r;                  // Bus write file address
	logic        hready_r;                   // Always-ready answer

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Resolve indirect access through the pointer register
	function automatic morf_pkg::morf_ref_t resolve(input logic [5:0] a,
		input logic [7:0] sel);
		morf_pkg::morf_ref_t r;
		r.bank = sel[7:6];
		r.addr = (a == `MORF_OFS_IND) ? sel[5:0] : a;
		r.ok   = (r.addr != `MORF_OFS_IND);
		return r;
	endfunction : resolve

	// Map a RAM file address to an array index
	function automatic logic [7:0] ram_index(input morf_pkg::morf_ref_t r);
		if (r.addr < `MORF_OFS_BANKED)
			return {2'b00, r.addr} - 8'h10;
		return 8'h10 + {1'b0, r.bank, 5'b00000} + {3'b000, r.addr[4:0]};
	endfunction : ram_index

	// Read any resolved file location
	function automatic logic [7:0] read_file(input morf_pkg::morf_ref_t r);
		if (!r.ok)
			return 8'h00;
		if (r.addr >= `MORF_OFS_RAM_LO)
			return ram_r[ram_index(r)];
		unique case (r.addr)
			`MORF_OFS_TMR:   return timer_r;
			`MORF_OFS_PCL:   return pc_r[7:0];
			`MORF_OFS_STAT:  return stat_r;
			`MORF_OFS_RSEL:  return rsel_r;
			`MORF_OFS_P5:    return ports_r.p5;
			`MORF_OFS_P6:    return ports_r.p6;
			`MORF_OFS_P7:    return ports_r.p7 & `MORF_P7_MASK;
			`MORF_OFS_P8:    return ports_r.p8;
			`MORF_OFS_P9:    return ports_r.p9 & `MORF_P9_MASK;
			`MORF_OFS_EECMD: return eecmd_r;
			`MORF_OFS_PDCTL: return pdctl_r;
			default:         return 8'h00;
		endcase
	endfunction : read_file

	// ---------------------------------------------------------------
	// Write port: core has priority over the bus
	// ---------------------------------------------------------------
	logic                bus_wr_ok;  // Bus write may land this cycle
	logic                wr_en;      // Some write this cycle
	logic [7:0]          wr_data;    // Data of that write
	morf_pkg::morf_ref_t wr_ref;     // Resolved target

	always_comb
	begin
		bus_wr_ok = dp_wr_r & ~dm_req.wr;
		wr_en     = dm_req.wr | bus_wr_ok;
		wr_data   = dm_req.wr ? dm_req.wdata : hwdata[7:0];
		wr_ref    = resolve(dm_req.wr ? dm_req.addr : dp_addr_r, rsel_r);
	end

	// Per-register write strobes
	function automatic logic hit(input logic [5:0] a);
		return wr_en & wr_ref.ok & (wr_ref.addr == a);
	endfunction : hit

	// ---------------------------------------------------------------
	// Data RAM
	// ---------------------------------------------------------------
	// No reset: contents are undefined at power-on
	always_ff @(posedge clk_sys)
	begin
		if (wr_en && wr_ref.ok && wr_ref.addr >= `MORF_OFS_RAM_LO)
			ram_r[ram_index(wr_ref)] <= wr_data;
	end

	// ---------------------------------------------------------------
	// Cycle timer and overflow flag
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			timer_r <= `MORF_RST_ZERO;
		else if (wdt_reset)
			timer_r <= `MORF_RST_ZERO;
		else if (hit(`MORF_OFS_TMR))
			timer_r <= wr_data;
		else if (instr_cycle)
			timer_r <= timer_r + 8'h01;
	end

	// Set wins over clear so a wrap is never lost
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			tof_r <= 1'b0;
		else if (instr_cycle && !wdt_reset && !hit(`MORF_OFS_TMR)
			&& timer_r == 8'hFF)
			tof_r <= 1'b1;
		else if (timer_flag_clr)
			tof_r <= 1'b0;
	end

	// Interrupt request only while enabled
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			irq_r <= 1'b0;
		else
			irq_r <= tof_r & timer_overflow_enable;
	end

	// ---------------------------------------------------------------
	// Program counter and stack
	// ---------------------------------------------------------------
	// A write to the low byte overrides the core command in that cycle
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			pc_r <= `MORF_PC_RESET;
			sp_r <= 3'd0;
		end
		else if (wdt_reset)
		begin
			pc_r <= `MORF_PC_RESET;
			sp_r <= 3'd0;
		end
		else if (hit(`MORF_OFS_PCL))
			pc_r <= {stat_r[7:5], 2'b00, wr_data};
		else
		begin
			unique case (pc_op)
				morf_pkg::MORF_PC_HOLD: ;
				morf_pkg::MORF_PC_STEP: pc_r <= pc_r + 13'd1;
				morf_pkg::MORF_PC_JUMP:
					pc_r <= {stat_r[7:5], jump_target};
				morf_pkg::MORF_PC_CALL:
				begin
					pc_r <= {stat_r[7:5], jump_target};
					sp_r <= sp_r + 3'd1;
				end
				morf_pkg::MORF_PC_RET:
				begin
					pc_r <= stack_r[sp_r - 3'd1];
					sp_r <= sp_r - 3'd1;
				end
				morf_pkg::MORF_PC_INT:
				begin
					pc_r <= `MORF_INT_VECTOR;
					sp_r <= sp_r + 3'd1;
				end
				default: ;
			endcase
		end
	end

	// Stack slots; a ninth push overwrites the oldest entry
	always_ff @(posedge clk_sys)
	begin
		if (!wdt_reset && !hit(`MORF_OFS_PCL))
		begin
			if (pc_op == morf_pkg::MORF_PC_CALL)
				stack_r[sp_r] <= pc_r + 13'd1;
			else if (pc_op == morf_pkg::MORF_PC_INT)
				stack_r[sp_r] <= pc_r;
		end
	end

	// ---------------------------------------------------------------
	// Status register
	// ---------------------------------------------------------------
	logic [8:0] sum9;   // Add with carry-out
	logic [4:0] sum5;   // Low nibble add
	logic [7:0] diff;   // Subtract result

	always_comb
	begin
		sum9 = {1'b0, alu_req.a} + {1'b0, alu_req.b};
		sum5 = {1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]};
		diff = alu_req.a - alu_req.b;
	end

	// Flags from the ALU override a software write of the same cycle
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			stat_r <= `MORF_RST_STAT;
		else
		begin
			if (hit(`MORF_OFS_STAT))
				stat_r <= (stat_r & ~`MORF_ST_WR_MASK)
					| (wr_data & `MORF_ST_WR_MASK);
			unique case (alu_req.op)
				morf_pkg::MORF_ALU_NONE: ;
				morf_pkg::MORF_ALU_ADD:
				begin
					stat_r[`MORF_ST_C]  <= sum9[8];
					stat_r[`MORF_ST_DC] <= sum5[4];
					stat_r[`MORF_ST_Z]  <= (sum9[7:0] == 8'h00);
				end
				morf_pkg::MORF_ALU_SUB:
				begin
					stat_r[`MORF_ST_C]  <= (alu_req.a >= alu_req.b);
					stat_r[`MORF_ST_DC] <= (alu_req.a[3:0] >= alu_req.b[3:0]);
					stat_r[`MORF_ST_Z]  <= (diff == 8'h00);
				end
				morf_pkg::MORF_ALU_RRC: stat_r[`MORF_ST_C] <= alu_req.a[0];
				morf_pkg::MORF_ALU_RLC: stat_r[`MORF_ST_C] <= alu_req.a[7];
				morf_pkg::MORF_ALU_LOGIC:
					stat_r[`MORF_ST_Z] <= (alu_req.a == 8'h00);
				default: ;
			endcase
			// Power flags; watchdog reset keeps power-down flag
			if (wdt_timeout || wdt_reset)
				stat_r[`MORF_ST_T] <= 1'b0;
			else if (watchdog_clear_instr)
			begin
				stat_r[`MORF_ST_T] <= 1'b1;
				stat_r[`MORF_ST_P] <= 1'b1;
			end
			else if (sleep_enter || port_wake)
			begin
				stat_r[`MORF_ST_T] <= 1'b1;
				stat_r[`MORF_ST_P] <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Pointer, port and control registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			rsel_r <= `MORF_RST_ZERO;
		else if (hit(`MORF_OFS_RSEL))
			rsel_r <= wr_data;
	end

	// Bit 3 of port 7 is not stored
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			ports_r <= '0;
		else
		begin
			if (hit(`MORF_OFS_P5)) ports_r.p5 <= wr_data;
			if (hit(`MORF_OFS_P6)) ports_r.p6 <= wr_data;
			if (hit(`MORF_OFS_P7)) ports_r.p7 <= wr_data & `MORF_P7_MASK;
			if (hit(`MORF_OFS_P8)) ports_r.p8 <= wr_data;
			if (hit(`MORF_OFS_P9)) ports_r.p9 <= wr_data & `MORF_P9_MASK;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			eecmd_r <= `MORF_RST_EECMD;
			pdctl_r <= `MORF_RST_ZERO;
		end
		else
		begin
			if (hit(`MORF_OFS_EECMD)) eecmd_r <= wr_data;
			if (hit(`MORF_OFS_PDCTL)) pdctl_r <= wr_data;
		end
	end

	// ---------------------------------------------------------------
	// Core read path, one cycle latency
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			dm_rdata_r <= 8'h00;
		else if (dm_req.rd)
			dm_rdata_r <= read_file(resolve(dm_req.addr, rsel_r));
	end

	// ---------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// ---------------------------------------------------------------
	logic bus_go;        // Valid word address phase
	logic bus_in_file;   // Address within the file window

	always_comb
	begin
		bus_go      = hsel & htrans[1] & hready & (hsize == 3'b010);
		bus_in_file = (haddr[31:8] == 24'h000000);
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			dp_wr_r   <= 1'b0;
			dp_addr_r <= 6'h00;
			hrdata_r  <= 32'h0000_0000;
			hready_r  <= 1'b0;
		end
		else
		begin
			hready_r  <= 1'b1;
			dp_wr_r   <= bus_go & hwrite & bus_in_file;
			dp_addr_r <= haddr[7:2];
			// Read data settles for the data phase; unmapped reads zero
			if (bus_go && !hwrite)
			begin
				if (bus_in_file)
					hrdata_r <= {24'h000000, read_file(resolve(haddr[7:2], rsel_r))};
				else if (haddr[31:2] == {20'h00000, `MORF_BUS_PC_ADDR})
					hrdata_r <= {16'h0000, sp_r, pc_r};
				else
					hrdata_r <= 32'h0000_0000;
			end
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	always_comb
	begin
		hreadyout           = hready_r;
		hresp               = 1'b0;
		hrdata              = hrdata_r;
		dm_rdata            = dm_rdata_r;
		fetch_addr          = pc_r;
		core_status         = stat_r;
		timer_overflow_flag = tof_r;
		timer_irq           = irq_r;
		port_data           = ports_r;
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// Plain expressions: a continuous assign would not follow the function's free signals
	logic pcl_wr;   // Low PC byte written this cycle
	logic tmr_wr;   // Timer written this cycle
	assign pcl_wr = wr_en & wr_ref.ok & (wr_ref.addr == `MORF_OFS_PCL);
	assign tmr_wr = wr_en & wr_ref.ok & (wr_ref.addr == `MORF_OFS_TMR);

	sequence call_s;
		pc_op == morf_pkg::MORF_PC_CALL && !wdt_reset && !pcl_wr;
	endsequence
	sequence ret_s;
		pc_op == morf_pkg::MORF_PC_RET && !wdt_reset && !pcl_wr;
	endsequence

	pc_reset_a: assert property (wdt_reset |=> pc_r == 13'h0000)
		else $error("pc not cleared by watchdog reset");
	int_vector_a: assert property (
		pc_op == morf_pkg::MORF_PC_INT && !wdt_reset && !pcl_wr |=> pc_r == 13'h0001)
		else $error("interrupt did not vector to one");
	call_ret_a: assert property (call_s ##1 ret_s |=> pc_r == $past(pc_r, 2) + 13'd1)
		else $error("return address wrong");
	timer_inc_a: assert property (
		instr_cycle && !wdt_reset && !tmr_wr |=> timer_r == $past(timer_r) + 8'h01)
		else $error("timer did not step");
	timer_wrap_a: assert property (
		instr_cycle && !wdt_reset && !tmr_wr && timer_r == 8'hFF
		|=> tof_r ##1 (timer_irq == $past(timer_overflow_enable)))
		else $error("overflow flag or irq wrong");
	pd_keep_a: assert property (
		wdt_reset && !watchdog_clear_instr |=> stat_r[3] == $past(stat_r[3]) && !stat_r[4])
		else $error("watchdog reset changed power flags");
	sleep_flags_a: assert property (
		(sleep_enter || port_wake) && !wdt_timeout && !wdt_reset && !watchdog_clear_instr
		|=> stat_r[4] && !stat_r[3])
		else $error("sleep or wake flags wrong");
	add_flags_a: assert property (
		alu_req.op == morf_pkg::MORF_ALU_ADD
		|=> stat_r[2] == ($past(sum9[7:0]) == 8'h00) && stat_r[0] == $past(sum9[8]))
		else $error("add flags wrong");
	ind_self_a: assert property (
		dm_req.rd && dm_req.addr == 6'h00 && rsel_r[5:0] == 6'h00 |=> dm_rdata == 8'h00)
		else $error("self-pointing indirect read not zero");
endmodule : morf_top
`default_nettype wire

// file: morf_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module morf_tb_top;
	// ---------------------------------------------------------------
	// Bench signals
	// ---------------------------------------------------------------
	logic                    clk_sys, rst, hsel, hwrite, hready;
	logic                    hreadyout, hresp, timer_overflow_flag, timer_irq;
	logic [31:0]             haddr, hwdata, hrdata, rd;
	logic [1:0]              htrans;
	logic [2:0]              hsize;
	logic                    wdt_reset, instr_cycle, watchdog_clear_instr;
	logic                    wdt_timeout, sleep_enter, port_wake;
	logic                    timer_overflow_enable, timer_flag_clr;
	logic [7:0]              dm_rdata, core_status, v;
	logic [7:0]              d [4];        // Per-bank random data
	logic [9:0]              jump_target;
	logic [12:0]             fetch_addr, exp_pc;
	logic [12:0]             stk [$];      // Expected return stack
	morf_pkg::morf_dm_req_t  dm_req;
	morf_pkg::morf_alu_req_t alu_req;
	morf_pkg::morf_pc_op_t   pc_op;
	morf_pkg::morf_ports_t   port_data;
	int                      err_count, compares;

	// One slave on the bus, so its ready is the bus ready
	assign hready = hreadyout;

	morf_top uut (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hreadyout, .hresp, .hrdata, .wdt_reset,
		.instr_cycle, .dm_req, .dm_rdata, .alu_req, .pc_op, .jump_target,
		.fetch_addr, .core_status, .watchdog_clear_instr, .wdt_timeout,
		.sleep_enter, .port_wake, .timer_overflow_enable, .timer_flag_clr,
		.timer_overflow_flag, .timer_irq, .port_data);

	// ---------------------------------------------------------------
	// Clock and watchdog
	// ---------------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Whole run is a few hundred cycles; this only cuts a hang
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		test_done;
	end

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task test_done;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	// Single word transfer; address and data held until ready seen high
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk_sys); while (hready !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(nm, rd, exp);
	endtask : rdc

	// Core data access; strobe lasts one cycle
	task dmx(input logic w, input logic [5:0] a, input logic [7:0] wd);
		dm_req <= '{rd: !w, wr: w, addr: a, wdata: wd};
		@(posedge clk_sys);
		dm_req <= '0;
		@(posedge clk_sys);
	endtask : dmx

	// Expected flags {Z,DC,C}; untouched bits keep their old value
	task alu(input int k, input logic [7:0] a, input logic [7:0] b);
		logic [2:0] e;
		e = core_status[2:0];
		alu_req <= '{op: morf_pkg::morf_alu_op_t'(k), a: a, b: b};
		case (k)
			1: e = {(a + b) % 256 == 0, {1'b0, a[3:0]} + b[3:0] > 5'h0F, {1'b0, a} + b > 9'h0FF};
			2: e = {a == b, a[3:0] >= b[3:0], a >= b};
			3: e[0] = a[0];
			4: e[0] = a[7];
			default: e[2] = (a == 8'h00);
		endcase
		@(posedge clk_sys);
		alu_req.op <= morf_pkg::MORF_ALU_NONE;
		@(negedge clk_sys);
		chk("alu flags", {29'h0, core_status[2:0]}, {29'h0, e});
		@(posedge clk_sys);
	endtask : alu

	// Program counter step with page code 5 held in status
	task pcop(input int k, input logic [9:0] t);
		pc_op <= morf_pkg::morf_pc_op_t'(k);
		jump_target <= t;
		@(posedge clk_sys);
		pc_op <= morf_pkg::MORF_PC_HOLD;
		case (k)
			1: exp_pc = exp_pc + 13'h0001;
			2: exp_pc = {3'h5, t};
			3:
			begin
				stk.push_back(exp_pc + 13'h0001);
				exp_pc = {3'h5, t};
			end
			4: exp_pc = stk.pop_back();
			default:
			begin
				stk.push_back(exp_pc);
				exp_pc = 13'h0001;
			end
		endcase
		@(negedge clk_sys);
		chk("fetch", fetch_addr, exp_pc);
		@(posedge clk_sys);
	endtask : pcop

	// One-cycle event pulse; tp is the expected {T,P} afterwards
	task pulse(input int k, input logic [1:0] tp);
		case (k)
			0: sleep_enter <= 1'b1;
			1: port_wake <= 1'b1;
			2: wdt_timeout <= 1'b1;
			3: watchdog_clear_instr <= 1'b1;
			4: wdt_reset <= 1'b1;
			5: instr_cycle <= 1'b1;
			default: timer_flag_clr <= 1'b1;
		endcase
		@(posedge clk_sys);
		{sleep_enter, port_wake, wdt_timeout, watchdog_clear_instr} <= 4'h0;
		{wdt_reset, instr_cycle, timer_flag_clr} <= 3'h0;
		@(negedge clk_sys);
		if (k < 5)
			chk("t p flags", {30'h0, core_status[4:3]}, {30'h0, tp});
		@(posedge clk_sys);
	endtask : pulse

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		void'($urandom(32'h0910));
		rst = 1'b1;
		{hsel, hwrite, haddr, hwdata, htrans} = '0;
		hsize = 3'h2;
		{wdt_reset, instr_cycle, watchdog_clear_instr, wdt_timeout} = '0;
		{sleep_enter, port_wake, timer_overflow_enable, timer_flag_clr} = '0;
		jump_target = '0;
		dm_req = '0;
		alu_req = '0;
		pc_op = morf_pkg::MORF_PC_HOLD;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		chk("status", core_status, 8'h18);
		chk("fetch", fetch_addr, 13'h0000);
		rdc("timer", 32'h04, 32'h00);
		rdc("eeprom cmd", 32'h28, 32'hFF);
		$display("test reset done");
		// Same offset in all four banks must stay apart
		for (int b = 0; b < 4; b++)
		begin
			d[b] = $urandom;
			ahb(1'b1, 32'h10, {24'h0, b[1:0], 6'h3C});
			dmx(1'b1, 6'h00, d[b]);
		end
		for (int b = 0; b < 4; b++)
		begin
			ahb(1'b1, 32'h10, {24'h0, b[1:0], 6'h3C});
			rdc("indirect", 32'h00, {24'h0, d[b]});
			rdc("banked", 32'hF0, {24'h0, d[b]});
		end
		ahb(1'b1, 32'h54, {24'h0, d[0] ^ 8'h5A});
		ahb(1'b1, 32'h10, 32'hD5);
		dmx(1'b0, 6'h00, 8'h00);
		chk("common", dm_rdata, d[0] ^ 8'h5A);
		ahb(1'b1, 32'h10, 32'h40);
		ahb(1'b1, 32'h00, 32'hA5);
		rdc("self pointer", 32'h00, 32'h00);
		dmx(1'b0, 6'h00, 8'h00);
		chk("self core", dm_rdata, 8'h00);
		ahb(1'b1, 32'h30, 32'hFF);
		rdc("unmapped", 32'h30, 32'h00);
		ahb(1'b1, 32'h1C, 32'hFF);
		rdc("port7", 32'h1C, 32'hF7);
		chk("port7 out", port_data.p7, 8'hF7);
		ahb(1'b1, 32'h24, 32'hFF);
		rdc("port9", 32'h24, 32'h6F);
		chk("port9 out", port_data.p9, 8'h6F);
		v = $urandom;
		ahb(1'b1, 32'h14, {24'h0, v});
		rdc("port5", 32'h14, {24'h0, v});
		chk("port5 out", port_data.p5, v);
		chk("hresp", hresp, 1'b0);
		$display("test memory done");
		// Timer wrap, mask and clear
		ahb(1'b1, 32'h04, 32'hFE);
		pulse(5, 2'h0);
		chk("tflag early", timer_overflow_flag, 1'b0);
		pulse(5, 2'h0);
		chk("tflag", timer_overflow_flag, 1'b1);
		chk("irq masked", timer_irq, 1'b0);
		timer_overflow_enable <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk("irq", timer_irq, 1'b1);
		rdc("timer wrap", 32'h04, 32'h00);
		pulse(6, 2'h0);
		chk("tflag clr", timer_overflow_flag, 1'b0);
		v = $urandom % 200;
		ahb(1'b1, 32'h04, {24'h0, v});
		repeat (3) pulse(5, 2'h0);
		rdc("timer step", 32'h04, {24'h0, v + 8'h03});
		$display("test timer done");
		// Carry corners first, then random operands for every flag source
		alu(1, 8'hFF, 8'h01);
		alu(2, 8'h00, 8'h01);
		alu(1, 8'h08, 8'h08);
		for (int i = 0; i < 40; i++)
			alu(1 + i % 5, $urandom, $urandom);
		$display("test alu done");
		// Page 5; arithmetic flags cleared by the same write
		ahb(1'b1, 32'h0C, 32'hA0);
		rdc("status", 32'h0C, 32'hB8);
		exp_pc = 13'h0000;
		pcop(2, 10'h3FF);
		rdc("pc low", 32'h08, 32'hFF);
		pcop(1, 10'h000);
		pcop(3, 10'h123);
		pcop(5, 10'h000);
		pcop(4, 10'h000);
		pcop(4, 10'h000);
		for (int i = 0; i < 8; i++)
			pcop(3, 10'(i));
		repeat (8) pcop(4, 10'h000);
		// Return straight after a call
		pc_op <= morf_pkg::MORF_PC_CALL;
		jump_target <= 10'h055;
		@(posedge clk_sys);
		pc_op <= morf_pkg::MORF_PC_RET;
		@(posedge clk_sys);
		pc_op <= morf_pkg::MORF_PC_HOLD;
		@(negedge clk_sys);
		exp_pc = exp_pc + 13'h0001;
		chk("call ret", fetch_addr, exp_pc);
		@(posedge clk_sys);
		rdc("pc word", 32'h100, {19'h0, exp_pc});
		// Low byte write takes the page bits from status
		ahb(1'b1, 32'h08, 32'h5A);
		@(negedge clk_sys);
		chk("pc write", fetch_addr, 13'h145A);
		@(posedge clk_sys);
		$display("test pc done");
		pulse(0, 2'b10);
		pulse(1, 2'b10);
		pulse(2, 2'b00);
		pulse(3, 2'b11);
		pulse(2, 2'b01);
		pulse(4, 2'b01);
		chk("fetch wdt", fetch_addr, 13'h0000);
		rdc("timer wdt", 32'h04, 32'h00);
		$display("test power done");
		test_done;
	end
endmodule : morf_tb_top
`default_nettype wire
